//--- core/pin_mux_regs.vh
// constants for the shared quadrature, timer, spi clock and test reset pin group
`ifndef PIN_MUX_REGS_VH
`define PIN_MUX_REGS_VH
`define PUD_JTAG_BIT      0
`define PORTC_PHASE_A_BIT 4
`define PORTC_PHASE_B_BIT 5
`define PORTC_MARKER_BIT  6
`define PORTC_REF_BIT     7
`define PORTE_SCLK_BIT    4
`define PORTC_PULL_RST    8'hff
`define PORTE_PULL_RST    8'hff
`define PUD_RST           8'h00
`define FUNC_PERIPH       2'h0
`define FUNC_TIMER        2'h1
`define FUNC_GPIO         2'h2
`endif

//--- core/quad_timer_spi_pin_mux.v
// pin mux and pull-up control for test reset, quadrature decoder 0 and spi 0 clock pins
`timescale 1ns/1ps
`include "pin_mux_regs.vh"
// Contract
// - a low on the test reset pin resets the test access port controller.
// - setting the jtag disable bit removes the test reset pull-up.
// - phase a pin: decoder phase a, timer ch0 or gpio; default phase a.
// - clearing port c bit 4 pull-up enable removes phase a pull-up.
// - phase b pin: decoder phase b, timer ch1 or gpio; default phase b.
// - clearing port c bit 5 pull-up enable removes phase b pull-up.
// - marker pin: decoder index, timer ch2 or gpio; default index.
// - clearing port c bit 6 pull-up enable removes marker pull-up.
// - reference pin: decoder home, timer ch3 or gpio; default home.
// - clearing port c bit 7 pull-up enable removes reference pull-up.
// - spi clock pin drives out in master mode, is clock input in slave.
// - spi clock pin shared with port e bit 4; default spi clock.
// - clearing port e bit 4 pull-up enable removes spi clock pull-up.
// - in gpio function each pin is individually input or output.
module quad_timer_spi_pin_mux (
	input  wire       core_clk_in,          // 125 MHz core clock
	input  wire       srst_in,              // synchronous reset, active high
	input  wire       clk_en_in,            // freezes all state while low and srst_in is low
	input  wire [7:0] pullup_disable_ctrl_in, // pull-up disable control, bit 0 jtag
	input  wire [7:0] portc_pullup_enable_in, // port c pull-up enables
	input  wire [7:0] porte_pullup_enable_in, // port e pull-up enables
	input  wire [7:0] quad_func_sel_in,     // 2-bit function per quad pin, pin0 in [1:0]
	input  wire       sclk_gpio_sel_in,     // 1 selects port e bit4 gpio on spi clock pin
	input  wire [4:0] gpio_dir_in,          // 1 = output, [3:0] port c 4..7, [4] port e 4
	input  wire [4:0] gpio_out_in,          // gpio output values, same order
	input  wire [3:0] timer_a_out_in,       // timer a ch0..3 output values
	input  wire [3:0] timer_a_oe_in,        // timer a ch0..3 drive enables
	input  wire       spi0_master_in,       // spi 0 in master mode
	input  wire       spi0_sclk_out_in,     // spi 0 clock from the spi block in master mode
	input  wire       test_reset_n_pin_in,  // test reset pin, active low
	input  wire [3:0] quad_pin_in,          // pad levels: phase a, phase b, marker, reference
	input  wire       sclk_pin_in,          // spi clock pad level
	output reg  [3:0] quad_pin_out,         // pad output values
	output reg  [3:0] quad_pin_oe_out,      // pad drive enables, high drives
	output reg  [3:0] quad_pull_en_out,     // pad pull-up enables
	output reg        sclk_pin_out,         // spi clock pad output
	output reg        sclk_pin_oe_out,      // spi clock pad drive enable
	output reg        sclk_pull_en_out,     // spi clock pad pull-up enable
	output reg        test_reset_pull_en_out, // test reset pad pull-up enable
	output reg        tap_reset_n_out,      // reset to the test access port, active low
	output reg        quad_phase_a_0_out,   // decoder 0 phase a input
	output reg        quad_phase_b_0_out,   // decoder 0 phase b input
	output reg        quad_marker_0_out,    // decoder 0 index input
	output reg        quad_reference_0_out, // decoder 0 home input
	output reg  [3:0] timer_a_in_out,       // timer a ch0..3 inputs
	output reg  [4:0] gpio_in_out,          // gpio input values, port c 4..7, port e 4
	output reg        spi0_sclk_in_out      // spi 0 clock input in slave mode
);

	// synchroniser stages for the pad inputs
	reg  [3:0] quad_meta_q;
	reg  [3:0] quad_sync_q;
	reg        sclk_meta_q;
	reg        sclk_sync_q;
	reg        trst_meta_q;
	reg        trst_sync_q;
	// registered pull-up controls
	reg  [7:0] portc_pull_q;
	reg  [7:0] porte_pull_q;
	reg  [7:0] pud_q;

	// code 3 is unused and falls back to the decoder function
	function [1:0] func_of;
		input [7:0] sel;
		input integer idx;
		begin
			func_of = sel[idx*2 +: 2];
			if (func_of != `FUNC_TIMER && func_of != `FUNC_GPIO)
				func_of = `FUNC_PERIPH;
		end
	endfunction

	// two-stage synchronisers for all pad inputs
	// reset to the pulled level so no false edge follows reset
	always @(posedge core_clk_in) begin
		if (srst_in) begin
			quad_meta_q <= 4'hf;
			quad_sync_q <= 4'hf;
			sclk_meta_q <= 1'h1;
			sclk_sync_q <= 1'h1;
			trst_meta_q <= 1'h1;
			trst_sync_q <= 1'h1;
		end else if (clk_en_in) begin
			quad_meta_q <= quad_pin_in;
			quad_sync_q <= quad_meta_q;
			sclk_meta_q <= sclk_pin_in;
			sclk_sync_q <= sclk_meta_q;
			trst_meta_q <= test_reset_n_pin_in;
			trst_sync_q <= trst_meta_q;
		end
	end

	// pull-up controls take one edge here and one more at the pad enables
	always @(posedge core_clk_in) begin
		if (srst_in) begin
			portc_pull_q <= `PORTC_PULL_RST;
			porte_pull_q <= `PORTE_PULL_RST;
			pud_q        <= `PUD_RST;
		end else if (clk_en_in) begin
			portc_pull_q <= portc_pullup_enable_in;
			porte_pull_q <= porte_pullup_enable_in;
			pud_q        <= pullup_disable_ctrl_in;
		end
	end

	// test reset: pin low resets the tap; not tied to device reset here
	always @(posedge core_clk_in) begin
		if (clk_en_in || srst_in)
			tap_reset_n_out <= trst_sync_q;
	end

	// test reset pull-up is on in reset, then follows the disable bit
	always @(posedge core_clk_in) begin
		if (srst_in)
			test_reset_pull_en_out <= 1'h1;
		else if (clk_en_in)
			test_reset_pull_en_out <= ~pud_q[`PUD_JTAG_BIT];
	end

	// per-pin output mux: only the selected function may drive the pad
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : quad_pin
			always @(posedge core_clk_in) begin
				if (srst_in) begin
					quad_pin_out[g]     <= 1'h0;
					quad_pin_oe_out[g]  <= 1'h0;
					quad_pull_en_out[g] <= 1'h1;
					timer_a_in_out[g]   <= 1'h0;
				end else if (clk_en_in) begin
					quad_pull_en_out[g] <= portc_pull_q[`PORTC_PHASE_A_BIT + g];
					// pad enables stay low for the decoder function
					case (func_of(quad_func_sel_in, g))
						`FUNC_TIMER: begin
							quad_pin_out[g]    <= timer_a_out_in[g];
							quad_pin_oe_out[g] <= timer_a_oe_in[g];
						end
						`FUNC_GPIO: begin
							quad_pin_out[g]    <= gpio_out_in[g];
							quad_pin_oe_out[g] <= gpio_dir_in[g];
						end
						default: begin
							quad_pin_out[g]    <= 1'h0;
							quad_pin_oe_out[g] <= 1'h0;
						end
					endcase
					if (func_of(quad_func_sel_in, g) == `FUNC_TIMER) begin
						timer_a_in_out[g] <= quad_sync_q[g];
					end else begin
						timer_a_in_out[g] <= 1'h0;
					end
				end
			end
		end
	endgenerate

	// gpio inputs: one process owns all five bits; unselected pins read 0
	integer i;
	always @(posedge core_clk_in) begin
		if (srst_in) begin
			gpio_in_out <= 5'h00;
		end else if (clk_en_in) begin
			for (i = 0; i < 4; i = i + 1) begin
				if (func_of(quad_func_sel_in, i) == `FUNC_GPIO) begin
					gpio_in_out[i] <= quad_sync_q[i];
				end else begin
					gpio_in_out[i] <= 1'h0;
				end
			end
			if (sclk_gpio_sel_in) begin
				gpio_in_out[4] <= sclk_sync_q;
			end else begin
				gpio_in_out[4] <= 1'h0;
			end
		end
	end

	// decoder inputs idle high (pulled) when the pin serves another function
	always @(posedge core_clk_in) begin
		if (srst_in) begin
			quad_phase_a_0_out   <= 1'h1;
			quad_phase_b_0_out   <= 1'h1;
			quad_marker_0_out    <= 1'h1;
			quad_reference_0_out <= 1'h1;
		end else if (clk_en_in) begin
			quad_phase_a_0_out   <= (func_of(quad_func_sel_in, 0) == `FUNC_PERIPH) ? quad_sync_q[0] : 1'h1;
			quad_phase_b_0_out   <= (func_of(quad_func_sel_in, 1) == `FUNC_PERIPH) ? quad_sync_q[1] : 1'h1;
			quad_marker_0_out    <= (func_of(quad_func_sel_in, 2) == `FUNC_PERIPH) ? quad_sync_q[2] : 1'h1;
			quad_reference_0_out <= (func_of(quad_func_sel_in, 3) == `FUNC_PERIPH) ? quad_sync_q[3] : 1'h1;
		end
	end

	// spi clock pin: spi function by default, gpio when selected
	always @(posedge core_clk_in) begin
		if (srst_in) begin
			sclk_pin_out     <= 1'h0;
			sclk_pin_oe_out  <= 1'h0;
			sclk_pull_en_out <= 1'h1;
			spi0_sclk_in_out <= 1'h0;
		end else if (clk_en_in) begin
			sclk_pull_en_out <= porte_pull_q[`PORTE_SCLK_BIT];
			if (sclk_gpio_sel_in) begin
				sclk_pin_out     <= gpio_out_in[4];
				sclk_pin_oe_out  <= gpio_dir_in[4];
				spi0_sclk_in_out <= 1'h0;
			end else begin
				sclk_pin_out     <= spi0_sclk_out_in;
				sclk_pin_oe_out  <= spi0_master_in;
				spi0_sclk_in_out <= spi0_master_in ? 1'h0 : sclk_sync_q;
			end
		end
	end

endmodule // quad_timer_spi_pin_mux

//--- tb/pin_mux_monitor.sv
// assertion checker for the shared pin group
`timescale 1ns/1ps
module pin_mux_monitor (
	input logic core_clk_in, srst_in, sclk_gpio_sel_in, spi0_master_in, test_reset_n_pin_in, // controls
	input logic [7:0] pullup_disable_ctrl_in, portc_pullup_enable_in, porte_pullup_enable_in, quad_func_sel_in, // cfg
	input logic [4:0] gpio_dir_in, gpio_in_out,                          // gpio
	input logic [3:0] timer_a_oe_in, quad_pin_in, quad_pin_oe_out, quad_pull_en_out, timer_a_in_out, // quad pins
	input logic sclk_pin_oe_out, sclk_pull_en_out, test_reset_pull_en_out, tap_reset_n_out, quad_phase_a_0_out // misc
);
	logic [2:0] run_q = 3'h0;
	wire live = &run_q;
	// three clean edges since reset so every pipeline stage holds real data
	always @(posedge core_clk_in) run_q <= {run_q[1:0], !srst_in};
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (srst_in);
	tap_follow_a: assert property (live |-> tap_reset_n_out == $past(test_reset_n_pin_in, 3)) else $error("tap");
	jtag_pull_a: assert property (live |-> test_reset_pull_en_out != $past(pullup_disable_ctrl_in[0], 2))
		else $error("test reset pull");
	quad_pull_a: assert property (live |-> quad_pull_en_out == $past(portc_pullup_enable_in[7:4], 2))
		else $error("quad pull");
	sclk_pull_a: assert property (live |-> sclk_pull_en_out == $past(porte_pullup_enable_in[4], 2))
		else $error("sclk pull");
	reset_state_a: assert property ($past(srst_in) |-> quad_pin_oe_out == 4'h0 && !sclk_pin_oe_out && &quad_pull_en_out
		&& sclk_pull_en_out && test_reset_pull_en_out) else $error("reset state");
	sclk_dir_a: assert property (live |-> sclk_pin_oe_out ==
		($past(sclk_gpio_sel_in) ? $past(gpio_dir_in[4]) : $past(spi0_master_in))) else $error("sclk drive");
	marker_oe_a: assert property (live |-> quad_pin_oe_out[2] == ($past(quad_func_sel_in[5:4]) == 2'h1 ?
		$past(timer_a_oe_in[2]) : $past(quad_func_sel_in[5:4]) == 2'h2 && $past(gpio_dir_in[2]))) else $error("marker oe");
	phase_a_route_a: assert property (live && !$past(^quad_func_sel_in[1:0]) |->
		quad_phase_a_0_out == $past(quad_pin_in[0], 3)) else $error("phase a route");
	timer_b_in_a: assert property (live |-> timer_a_in_out[1] ==
		($past(quad_func_sel_in[3:2]) == 2'h1 && $past(quad_pin_in[1], 3))) else $error("timer ch1 in");
	home_gpio_a: assert property (live |-> gpio_in_out[3] ==
		($past(quad_func_sel_in[7:6]) == 2'h2 && $past(quad_pin_in[3], 3))) else $error("home gpio in");
endmodule // pin_mux_monitor
bind quad_timer_spi_pin_mux pin_mux_monitor mon (.*);

//--- tb/pad_side_model.sv
// pad-side model: encoders and spi peer driving the shared pins
`timescale 1ns/1ps
module pad_side_model (
	input  logic       core_clk_in, // clock
	input  logic [4:0] drv_in,      // far side drives the pad
	input  logic [4:0] val_in,      // far side level
	input  logic [4:0] oe_in,       // device drive enables
	input  logic [4:0] out_in,      // device pad values
	input  logic [4:0] pull_in,     // device pull-ups
	output logic [4:0] pad_out      // resolved pad levels
);
	logic [4:0] flt_q = 5'h0;
	// a released pad without pull-up wanders rather than holding its last level
	always @(posedge core_clk_in) flt_q <= ~flt_q;
	always_comb for (int i = 0; i < 5; i++)
		pad_out[i] = oe_in[i] ? out_in[i] : drv_in[i] ? val_in[i] : pull_in[i] ? 1'b1 : flt_q[i];
endmodule // pad_side_model

//--- tb/quad_timer_spi_pin_mux_tb_top.sv
// self-checking bench for the shared pin group
`timescale 1ns/1ps
module quad_timer_spi_pin_mux_tb_top;
	logic core_clk_in = 0, srst_in = 1, clk_en_in = 1, sclk_gpio_sel_in = 0, spi0_master_in = 0, spi0_sclk_out_in = 0;
	logic test_reset_n_pin_in = 0;
	logic [7:0] pullup_disable_ctrl_in = 0, portc_pullup_enable_in = 8'hff, porte_pullup_enable_in = 8'hff;
	logic [7:0] quad_func_sel_in = 0;
	logic [4:0] gpio_dir_in = 0, gpio_out_in = 0, drv = 0, val = 0;
	logic [3:0] timer_a_out_in = 0, timer_a_oe_in = 0;
	wire [3:0] quad_pin_in, quad_pin_out, quad_pin_oe_out, quad_pull_en_out, timer_a_in_out;
	wire [4:0] gpio_in_out;
	wire sclk_pin_in, sclk_pin_out, sclk_pin_oe_out, sclk_pull_en_out, test_reset_pull_en_out, tap_reset_n_out;
	wire quad_phase_a_0_out, quad_phase_b_0_out, quad_marker_0_out, quad_reference_0_out, spi0_sclk_in_out;
	int unsigned seed = 95465;
	int error_cnt = 0, compares = 0;
	logic [25:0] q[$];
	quad_timer_spi_pin_mux dut (.*);
	pad_side_model far (.core_clk_in(core_clk_in), .drv_in(drv), .val_in(val), .oe_in({sclk_pin_oe_out, quad_pin_oe_out}),
		.out_in({sclk_pin_out, quad_pin_out}), .pull_in({sclk_pull_en_out, quad_pull_en_out}), .pad_out({sclk_pin_in, quad_pin_in}));
	initial forever #4 core_clk_in = ~core_clk_in;
	function automatic int unsigned rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic test_done();
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic check(input logic [25:0] seen, input logic [25:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch pin group expected %h seen %h", exp, seen);
		end
	endtask
	always @(negedge core_clk_in) while (q.size() > 0) begin
		check({quad_pin_oe_out, quad_pull_en_out, timer_a_in_out, gpio_in_out, sclk_pin_oe_out, sclk_pull_en_out,
			test_reset_pull_en_out, tap_reset_n_out, quad_reference_0_out, quad_marker_0_out, quad_phase_b_0_out,
			quad_phase_a_0_out, spi0_sclk_in_out}, q[0]);
		void'(q.pop_front());
	end
	task automatic rst(input logic tr);
		srst_in <= 1;
		test_reset_n_pin_in <= tr;
		repeat (10) @(posedge core_clk_in);
		test_reset_n_pin_in <= 1;
		repeat (6) @(posedge core_clk_in);
		q.push_back({4'h0, 4'hf, 9'h000, 4'h7, 4'hf, 1'b0});
		srst_in <= 0;
	endtask
	task automatic expect_now();
		logic [3:0] oe, p, dec, tin, gin;
		logic [1:0] s;
		logic soe, sp;
		for (int g = 0; g < 4; g++) begin
			s = quad_func_sel_in[2*g +: 2];
			oe[g] = s == 2'h1 ? timer_a_oe_in[g] : s == 2'h2 && gpio_dir_in[g];
			p[g] = oe[g] ? (s == 2'h1 ? timer_a_out_in[g] : gpio_out_in[g]) : drv[g] ? val[g] : 1'b1;
			dec[g] = s == 2'h1 || s == 2'h2 ? 1'b1 : p[g];
			tin[g] = s == 2'h1 && p[g];
			gin[g] = s == 2'h2 && p[g];
		end
		soe = sclk_gpio_sel_in ? gpio_dir_in[4] : spi0_master_in;
		sp = soe ? (sclk_gpio_sel_in ? gpio_out_in[4] : spi0_sclk_out_in) : drv[4] ? val[4] : 1'b1;
		q.push_back({oe, portc_pullup_enable_in[7:4], tin, sclk_gpio_sel_in && sp, gin, soe, porte_pullup_enable_in[4],
			!pullup_disable_ctrl_in[0], test_reset_n_pin_in, dec, !sclk_gpio_sel_in && !spi0_master_in && sp});
	endtask
	initial begin
		logic [31:0] r, t;
		rst(1'b0);
		for (int k = 0; k < 300; k++) begin
			if (k == 150) rst(1'b1);
			@(posedge core_clk_in);
			r = rnd();
			t = rnd();
			{spi0_sclk_out_in, spi0_master_in, sclk_gpio_sel_in, test_reset_n_pin_in, val, drv} <= r[13:0];
			{timer_a_oe_in, timer_a_out_in, gpio_out_in, gpio_dir_in, quad_func_sel_in} <= t[25:0];
			pullup_disable_ctrl_in <= r[21:14];
			portc_pullup_enable_in <= r[29:22] | {~r[3:0], 4'h0};
			porte_pullup_enable_in <= t[31:24] | {3'h0, ~r[4], 4'h0};
			repeat (6) @(posedge core_clk_in);
			expect_now();
		end
		repeat (2) @(posedge core_clk_in);
		test_done();
	end
	initial begin
		#200000;
		error_cnt++;
		test_done();
	end
endmodule // quad_timer_spi_pin_mux_tb_top
